// file: hdl/eho_edge_if.sv
`timescale 1ns/1ps
// Carries the filtered edge pulses from the pin synchroniser to the timer.
interface eho_edge_if;
  logic rise;
  logic fall;
  modport src (output rise, output fall);
  modport dst (input rise, input fall);
endinterface

// file: hdl/eho_edge_sync.sv
`timescale 1ns/1ps
module eho_edge_sync
  import eho_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic pin_in,
  eho_edge_if.src   ev
);

  logic [2:0] sync_r;
  logic       level_r;

  // Three flops; the first is only ever read by the second.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync_r <= 3'h0;
    end else begin
      sync_r <= {sync_r[1:0], pin_in};
    end
  end

  // A new level is accepted only once stages two and three agree, which rejects one-cycle glitches.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      level_r <= 1'b0;
    end else if (sync_r[1] == sync_r[2]) begin
      level_r <= sync_r[2];
    end
  end

  // Edge pulses last one cycle; they are combinational from the accepted level.
  assign ev.rise = (sync_r[1] == sync_r[2]) && sync_r[2] && !level_r;
  assign ev.fall = (sync_r[1] == sync_r[2]) && !sync_r[2] && level_r;

endmodule

// file: hdl/eho_pkg.sv
package eho_pkg;

  // Widths of the counter, of the register port and of the divider.
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned DIV_W  = 16;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PERIOD = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PULSE  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_COUNT  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;

  // Control register field positions.
  localparam int unsigned CTRL_ON_BIT   = 0;
  localparam int unsigned CTRL_MODE_LSB = 1;
  localparam int unsigned CTRL_MODE_W   = 5;
  localparam int unsigned CTRL_LINK_BIT = 6;

  // Status register field positions.
  localparam int unsigned STAT_RUN_BIT  = 0;
  localparam int unsigned STAT_HOLD_BIT = 1;
  localparam int unsigned STAT_PWM_BIT  = 2;
  localparam int unsigned STAT_ON_BIT   = 3;

  // Mode encodings and reset values.
  localparam logic [CTRL_MODE_W-1:0] MODE_RISE  = 5'h0C;
  localparam logic [CTRL_MODE_W-1:0] MODE_FALL  = 5'h0D;
  localparam logic [CTRL_MODE_W-1:0] MODE_RST   = 5'h00;
  localparam logic [CNT_W-1:0]       PERIOD_RST = 16'hFFFF;
  localparam logic [CNT_W-1:0]       PULSE_RST  = 16'h0000;

  // Timer clocks the counter is held after a reset edge.
  localparam logic [1:0] HOLD_TICKS = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_HOLD = 2'b10
  } eho_state_e;

endpackage

// file: hdl/eho_timer.sv
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
// Function
// R1: With enable set, the first qualifying pin edge starts the counter.
// R2: Later qualifying edges zero the counter; counting resumes two timer clocks later.
// R3: Mode 01100 uses rising edges, mode 01101 uses falling edges.
// R4: Counter equal to period zeroes the counter and clears enable.
// R5: While enable is clear, pin edges have no effect at all.
// R6: With PWM linked, start and reset edges switch the PWM drive on.
// R7: PWM drive goes off at pulse-width match and stays off until the next start or reset edge.
// R8: While running and not held, counter steps by one per timer clock from zero.
module eho_timer
  import eho_pkg::*;
#(
  parameter int unsigned          CNT_WIDTH = CNT_W,
  parameter logic [DIV_W-1:0]     DIV       = 16'h0001
)(
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rd_data,
  input  wire logic              trig_in,
  output logic                   pwm_out
);

  // Selects the qualifying edge for the current mode; other modes qualify nothing.
  function automatic logic edge_sel(input logic [CTRL_MODE_W-1:0] m, input logic r, input logic f);
    logic q;
    q = 1'b0;
    if (m == MODE_RISE) begin
      q = r;
    end else if (m == MODE_FALL) begin
      q = f;
    end
    return q;
  endfunction

  // Pin edges reach the timer through a three-flop filter, so an edge acts about three cycles late.
  // Keeping the filter in its own module leaves the timer with same-clock pulses only.
  eho_edge_if ev_if ();

  eho_edge_sync u_sync (
    .clk_sys (clk_sys),
    .srst    (srst),
    .pin_in  (trig_in),
    .ev      (ev_if.src)
  );

  // Software-visible configuration and the timer's own state.
  logic                   on_r;
  logic [CTRL_MODE_W-1:0] mode_r;
  logic                   link_r;
  logic [CNT_WIDTH-1:0]   period_r;
  logic [CNT_WIDTH-1:0]   pulse_r;
  logic [CNT_WIDTH-1:0]   count_r;
  logic [1:0]             hold_r;
  logic [DIV_W-1:0]       div_r;
  eho_state_e             state_r;
  logic                   pwm_r;
  logic [DATA_W-1:0]      rd_data_r;

  // Decoded strobes and match terms, all combinational.
  logic                   wr_ctrl;
  logic                   ctrl_off_wr;
  logic                   tick;
  logic                   qual;
  logic                   go;
  logic                   hit_period;
  logic                   hit_pulse;
  logic                   halt;

  // Register port decode.
  assign wr_ctrl     = wr_en && (addr == OFF_CTRL);
  assign ctrl_off_wr = wr_ctrl && !wr_data[CTRL_ON_BIT];

  // Timer clock enable from the divider; DIV of one ticks every cycle.
  // A larger DIV stretches every count, the two-clock hold included.
  assign tick = (div_r == DIV - 16'h0001);

  always_ff @(posedge clk_sys) begin
    if (srst || tick) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end

  // An edge only acts while enabled and not being disabled in the same cycle.
  assign qual = edge_sel(mode_r, ev_if.rise, ev_if.fall); // R3
  assign go   = on_r && qual && !ctrl_off_wr; // R5

  // An edge in the same cycle as the period match wins: the timer restarts instead of halting.
  assign hit_period = (count_r == period_r);
  assign hit_pulse  = (count_r == pulse_r);
  assign halt       = (state_r == ST_RUN) && tick && hit_period && !go;

  // Configuration registers written by software.
  // COUNT and STATUS take no writes, and writes to unmapped offsets are dropped.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode_r   <= MODE_RST;
      link_r   <= 1'b0;
      period_r <= PERIOD_RST[CNT_WIDTH-1:0];
      pulse_r  <= PULSE_RST[CNT_WIDTH-1:0];
    end else if (wr_en) begin
      if (addr == OFF_CTRL) begin
        mode_r <= wr_data[CTRL_MODE_LSB +: CTRL_MODE_W];
        link_r <= wr_data[CTRL_LINK_BIT];
      end
      if (addr == OFF_PERIOD) begin
        period_r <= wr_data[CNT_WIDTH-1:0];
      end
      if (addr == OFF_PULSE) begin
        pulse_r <= wr_data[CNT_WIDTH-1:0];
      end
    end
  end

  // Enable bit: software write wins over the hardware clear in the same cycle.
  // The write wins so that a restart written in the match cycle is not lost.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      on_r <= 1'b0;
    end else if (wr_ctrl) begin
      on_r <= wr_data[CTRL_ON_BIT];
    end else if (halt) begin
      on_r <= 1'b0; // R4
    end
  end

  // Sequencer: waiting for the start edge, counting, or held after a reset edge.
  // The start edge goes straight to counting; only later reset edges pass through the hold.
  always_ff @(posedge clk_sys) begin
    if (srst || ctrl_off_wr) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (go) begin
            state_r <= ST_RUN; // R1
          end
        end
        ST_RUN: begin
          if (go) begin
            state_r <= ST_HOLD; // R2
          end else if (halt) begin
            state_r <= ST_IDLE; // R4
          end
        end
        ST_HOLD: begin
          if (!go && tick && (hold_r == 2'h1)) begin
            state_r <= ST_RUN; // R2
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Hold count: each reset edge reloads it, so back-to-back edges extend the hold.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hold_r <= 2'h0;
    end else if (go && (state_r != ST_IDLE)) begin
      hold_r <= HOLD_TICKS; // R2
    end else if ((state_r == ST_HOLD) && tick && (hold_r != 2'h0)) begin
      hold_r <= hold_r - 2'h1;
    end
  end

  // Counter: zeroed by edges, by the period match and by disabling.
  // A period written below the running count is only met after the counter wraps.
  always_ff @(posedge clk_sys) begin
    if (srst || ctrl_off_wr || go || halt) begin
      count_r <= '0; // R4
    end else if ((state_r == ST_RUN) && tick) begin
      count_r <= count_r + 1'b1; // R8
    end
  end

  // PWM drive: edges switch it on, the pulse-width or period match switches it off.
  // Clearing the link bit forces the drive off at once rather than at the next match.
  always_ff @(posedge clk_sys) begin
    if (srst || ctrl_off_wr) begin
      pwm_r <= 1'b0;
    end else if (go && link_r) begin
      pwm_r <= 1'b1; // R6
    end else if (!link_r) begin
      pwm_r <= 1'b0;
    end else if ((state_r == ST_RUN) && tick && (hit_pulse || hit_period)) begin
      pwm_r <= 1'b0; // R7
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped offsets read zero.
  // Returning zero outside that cycle lets a bus mux simply OR several slaves together.
  always_ff @(posedge clk_sys) begin
    if (srst || !rd_en) begin
      rd_data_r <= '0;
    end else begin
      case (addr)
        OFF_CTRL: begin
          rd_data_r <= '0;
          rd_data_r[CTRL_ON_BIT] <= on_r;
          rd_data_r[CTRL_MODE_LSB +: CTRL_MODE_W] <= mode_r;
          rd_data_r[CTRL_LINK_BIT] <= link_r;
        end
        OFF_PERIOD: begin
          rd_data_r <= DATA_W'(period_r);
        end
        OFF_PULSE: begin
          rd_data_r <= DATA_W'(pulse_r);
        end
        OFF_COUNT: begin
          rd_data_r <= DATA_W'(count_r);
        end
        OFF_STATUS: begin
          rd_data_r <= '0;
          rd_data_r[STAT_RUN_BIT]  <= (state_r == ST_RUN);
          rd_data_r[STAT_HOLD_BIT] <= (state_r == ST_HOLD);
          rd_data_r[STAT_PWM_BIT]  <= pwm_r;
          rd_data_r[STAT_ON_BIT]   <= on_r;
        end
        default: begin
          rd_data_r <= '0;
        end
      endcase
    end
  end

  assign rd_data = rd_data_r;
  assign pwm_out = pwm_r;

  // Checks on the sequencer, counter and drive.
  start_edge_a : assert property (@(posedge clk_sys) disable iff (srst) // R1
    (state_r == ST_IDLE) && go |=> (state_r == ST_RUN) && (count_r == '0))
    else $error("start edge did not start the counter");

  hold_two_a : assert property (@(posedge clk_sys) disable iff (srst) // R2
    (DIV == 16'h0001) && (state_r == ST_RUN) && go && !wr_en |=> (count_r == '0) [*3] ##1 (state_r != ST_HOLD))
    else $error("reset edge hold is not two timer clocks");

  mode_edge_a : assert property (@(posedge clk_sys) disable iff (srst) // R3
    (state_r == ST_IDLE) && on_r && !wr_en && (mode_r == MODE_RISE) && !ev_if.rise |=> (state_r == ST_IDLE))
    else $error("rising mode started on a non-rising edge");

  period_halt_a : assert property (@(posedge clk_sys) disable iff (srst) // R4
    (state_r == ST_RUN) && tick && hit_period && !go && !wr_en |=> !on_r && (count_r == '0) && (state_r == ST_IDLE))
    else $error("period match did not halt the timer");

  off_ignore_a : assert property (@(posedge clk_sys) disable iff (srst) // R5
    !on_r && !wr_en && (state_r == ST_IDLE) |=> (state_r == ST_IDLE) && !pwm_r)
    else $error("edge acted while disabled");

  pwm_on_a : assert property (@(posedge clk_sys) disable iff (srst) // R6
    go && link_r && !wr_en |=> pwm_r)
    else $error("edge did not switch the drive on");

  pwm_off_a : assert property (@(posedge clk_sys) disable iff (srst) // R7
    !pwm_r && !go ##1 !go |-> !pwm_r)
    else $error("drive came on without an edge");

  pulse_match_a : assert property (@(posedge clk_sys) disable iff (srst) // R7
    (state_r == ST_RUN) && tick && hit_pulse && !go |=> !pwm_r)
    else $error("pulse-width match left the drive on");

  count_step_a : assert property (@(posedge clk_sys) disable iff (srst) // R8
    (state_r == ST_RUN) && tick && !go && !hit_period && !wr_en |=> count_r == $past(count_r) + 1'b1)
    else $error("counter did not step by one");

  // Hold, idle, enable and drive checks that the scenarios cross only in passing.
  hold_reload_a : assert property (@(posedge clk_sys) disable iff (srst) // R2
    go && (state_r != ST_IDLE) |=> (state_r == ST_HOLD) && (hold_r == HOLD_TICKS))
    else $error("reset edge did not reload the hold");

  hold_zero_a : assert property (@(posedge clk_sys) disable iff (srst) // R2
    (state_r == ST_HOLD) |-> (count_r == '0))
    else $error("counter moved while held");

  idle_frozen_a : assert property (@(posedge clk_sys) disable iff (srst) // R5
    (state_r == ST_IDLE) && !go && !wr_en |=> (state_r == ST_IDLE) && $stable(count_r))
    else $error("idle timer moved without an edge");

  halted_zero_a : assert property (@(posedge clk_sys) disable iff (srst) // R4
    !on_r && (state_r == ST_IDLE) |-> (count_r == '0))
    else $error("halted timer kept a count");

  enable_keep_a : assert property (@(posedge clk_sys) disable iff (srst) // R4
    !halt && !wr_en |=> $stable(on_r))
    else $error("enable changed without a write or a halt");

  link_off_a : assert property (@(posedge clk_sys) disable iff (srst) // R6
    !link_r |=> !pwm_r)
    else $error("drive came on while unlinked");

  drive_halt_a : assert property (@(posedge clk_sys) disable iff (srst) // R7
    halt |=> !pwm_r)
    else $error("drive stayed on past the halt");

  drive_held_a : assert property (@(posedge clk_sys) disable iff (srst) // R6
    pwm_r && link_r && (state_r == ST_HOLD) && !wr_en |=> pwm_r)
    else $error("drive dropped during the hold");

endmodule

// file: testbench/eho_timer_tb.sv
`timescale 1ns/1ps
module eho_timer_tb
  import eho_pkg::*;
;
  localparam logic [DATA_W-1:0] PER = 32'h0000_0028;
  localparam logic [DATA_W-1:0] PUL = 32'h0000_000A;
  logic              clk_sys = 1'b0;
  logic              srst    = 1'b1;
  logic [ADDR_W-1:0] addr    = 8'h00;
  logic [DATA_W-1:0] wr_data = 32'h0000_0000;
  logic              wr_en   = 1'b0;
  logic              rd_en   = 1'b0;
  logic [DATA_W-1:0] rd_data;
  logic              trig_in;
  logic              pwm_out;
  logic [DATA_W-1:0] v;
  logic [DATA_W-1:0] ctl;
  logic [CTRL_MODE_W-1:0] modes [2] = '{MODE_RISE, MODE_FALL};
  logic              act;
  int                err_count = 0;
  int                total_checks = 0;
  int                n;

  // Free-running system clock.
  always #5 clk_sys = ~clk_sys;

  eho_timer #(.CNT_WIDTH(CNT_W), .DIV(16'h0001)) dut_u (
    .clk_sys(clk_sys), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .trig_in(trig_in), .pwm_out(pwm_out));
  eho_trig_src src_u (.clk_sys(clk_sys), .trig_in(trig_in));

  task automatic chk(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bus cycles: strobe for one cycle; the next call waits a fresh edge, so strobes never collide.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk_sys);
    wr_en   <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask

  // Counts edges until the drive shows the wanted level; the cap keeps a dead output from hanging.
  task automatic wait_pwm(input logic lvl, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk_sys);
      #1 cnt++;
    end while (pwm_out !== lvl && cnt < 200);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short; the full run needs well under a thousand cycles.
  initial begin
    #100000;
    err_count++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    rd(OFF_CTRL, v);   chk("ctrl_reset", v, 32'h0000_0000);
    rd(OFF_PERIOD, v); chk("period_reset", v, {16'h0000, PERIOD_RST});
    rd(OFF_PULSE, v);  chk("pulse_reset", v, {16'h0000, PULSE_RST});
    wr(8'h14, 32'h0000_00FF);
    rd(8'h14, v);      chk("unmapped", v, 32'h0000_0000);
    wr(OFF_CTRL, (32'h1 << CTRL_LINK_BIT) | (32'(MODE_RISE) << CTRL_MODE_LSB));
    src_u.set_level(1'b1);
    src_u.set_level(1'b0);
    repeat (6) @(posedge clk_sys);
    rd(OFF_STATUS, v); chk("edge_while_off", v, 32'h0000_0000);
    wr(OFF_PERIOD, PER);
    wr(OFF_PULSE, PUL);
    wr(OFF_COUNT, 32'h0000_0055);
    rd(OFF_COUNT, v);  chk("count_ro", v, 32'h0000_0000);
    $display("test reset_and_idle done");
    // Same one-shot sequence in each edge mode, with the drive linked.
    foreach (modes[i]) begin
      act = (modes[i] == MODE_RISE);
      ctl = (32'h1 << CTRL_LINK_BIT) | (32'(modes[i]) << CTRL_MODE_LSB) | 32'h1;
      src_u.set_level(!act);
      repeat (4) @(posedge clk_sys);
      wr(OFF_CTRL, ctl);
      src_u.set_level(act);
      wait_pwm(1'b1, n); chk("start_drive", 32'(n < 12), 32'h1);
      rd(OFF_COUNT, v);  chk("count_after_start", v, 32'h1);
      wait_pwm(1'b0, n); chk("pulse_match", n, PUL - 32'h1);
      src_u.set_level(!act);
      src_u.set_level(act);
      wait_pwm(1'b1, n); chk("reset_drive", 32'(n < 12), 32'h1);
      wait_pwm(1'b0, n); chk("held_pulse", n, PUL + 32'h3);
      rd(OFF_COUNT, v);  chk("count_held", v, PUL + 32'h2);
      repeat (26) @(posedge clk_sys);
      rd(OFF_COUNT, v);  chk("count_at_period", v, PER);
      rd(OFF_CTRL, v);   chk("enable_cleared", v, ctl & ~32'h1);
      rd(OFF_COUNT, v);  chk("count_halted", v, 32'h0000_0000);
      src_u.set_level(!act);
      src_u.set_level(act);
      repeat (6) @(posedge clk_sys);
      rd(OFF_STATUS, v); chk("edge_after_halt", v, 32'h0000_0000);
      chk("drive_after_halt", {31'h0, pwm_out}, 32'h0000_0000);
      $display("test one_shot mode %h done", modes[i]);
    end
    // Enabled with an undecoded mode, then a rising start without the drive link, then a stop.
    wr(OFF_CTRL, (32'h1 << CTRL_LINK_BIT) | 32'h1);
    src_u.set_level(1'b0);
    src_u.set_level(1'b1);
    repeat (6) @(posedge clk_sys);
    rd(OFF_STATUS, v); chk("undecoded_mode", v, 32'h1 << STAT_ON_BIT);
    wr(OFF_CTRL, (32'(MODE_RISE) << CTRL_MODE_LSB) | 32'h1);
    src_u.set_level(1'b0);
    src_u.set_level(1'b1);
    repeat (6) @(posedge clk_sys);
    rd(OFF_STATUS, v); chk("unlinked_start", v, (32'h1 << STAT_ON_BIT) | (32'h1 << STAT_RUN_BIT));
    chk("unlinked_drive", {31'h0, pwm_out}, 32'h0000_0000);
    wr(OFF_CTRL, 32'h0000_0000);
    rd(OFF_STATUS, v); chk("stopped", v, 32'h0000_0000);
    rd(OFF_COUNT, v);  chk("count_stopped", v, 32'h0000_0000);
    $display("test undecoded_and_unlinked done");
    end_of_test();
  end
endmodule

// file: testbench/eho_trig_src.sv
`timescale 1ns/1ps
// Model of the external start/reset pin source.
module eho_trig_src (
  input  wire logic clk_sys,
  output logic      trig_in
);
  logic prev = 1'b0;
  int   stable = 0;
  initial trig_in = 1'b0;
  // Cycles since the pin last changed; the pin filter needs two stable cycles to see a level.
  always @(posedge clk_sys) begin
    prev   <= trig_in;
    stable <= (trig_in != prev) ? 0 : stable + 1;
  end
  // Waits out the stability floor before moving the pin, so no edge is ever lost.
  // The counter lags the pin by a cycle, so a change it has not yet seen also holds the pin.
  task automatic set_level(input logic lvl);
    do @(posedge clk_sys); while (stable < 4 || trig_in != prev);
    trig_in <= lvl;
  endtask
endmodule
